/* src/ptm_periodic_timer.v */
// Periodic timer: 10-bit up-counter, comparators A and P, Wishbone register slave, output pins.
// Assumes one 125 MHz clock, synchronous pins, and sub and high clocks given as enable pulses.
`timescale 1ns/1ps
`include "ptm_timer_map.vh"
module ptm_periodic_timer #(
  parameter CNT_W = 10
) (
  // Clock and reset.
  input  wire             clk,
  input  wire             rst_n,
  // Wishbone classic slave.
  input  wire             wb_cyc_i,
  input  wire             wb_stb_i,
  input  wire             wb_we_i,
  input  wire [3:0]       wb_adr_i,
  input  wire [7:0]       wb_dat_i,
  input  wire             wb_sel_i,
  output reg  [7:0]       wb_dat_o,
  output reg              wb_ack_o,
  // Clock enables from the oscillator block.
  input  wire             highClkEn,
  input  wire             subClkEn,
  // Pins.
  input  wire             externalClockPin,
  input  wire             captureInputPin,
  output reg              timerOutputPin,
  output reg              timerOutputInvertedPin,
  // Events.
  output reg              matchAPulse,
  output reg              matchPPulse
);
  // Control registers and shared staging buffer.
  reg  [7:0]       ctrl0_ff;
  reg  [7:0]       ctrl1_ff;
  reg  [7:0]       stageBuf_ff;
  reg  [CNT_W-1:0] counter_ff;
  reg  [CNT_W-1:0] cmpA_ff;
  reg  [CNT_W-1:0] cmpP_ff;
  reg  [CNT_W-1:0] capture_ff;
  reg              runPrev_ff;
  reg              outLevel_ff;
  reg              extPrev_ff;
  reg              trigPrev_ff;
  reg              pulseDone_ff;
  reg  [1:0]       status_ff;
  reg  [7:0]       divSys_ff;
  reg  [7:0]       divHigh_ff;
  wire             countPause   = ctrl0_ff[`PTM_C0_PAUSE];
  wire [2:0]       clockSelect  = ctrl0_ff[`PTM_C0_CKSEL_HI:`PTM_C0_CKSEL_LO];
  wire             runEnable    = ctrl0_ff[`PTM_C0_RUN];
  wire [1:0]       modeSelect   = ctrl1_ff[`PTM_C1_MODE_HI:`PTM_C1_MODE_LO];
  wire [1:0]       pinFunction  = ctrl1_ff[`PTM_C1_PIN_HI:`PTM_C1_PIN_LO];
  wire             outputCtl    = ctrl1_ff[`PTM_C1_OCTL];
  wire             outputPol    = ctrl1_ff[`PTM_C1_POL];
  wire             captureSrc   = ctrl1_ff[`PTM_C1_CAPSRC];
  wire             clearSel     = ctrl1_ff[`PTM_C1_CLRSEL];
  wire             runRise      = runEnable & ~runPrev_ff;
  wire             busReq       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire             busWr        = busReq & wb_we_i & wb_sel_i;
  wire             busRd        = busReq & ~wb_we_i;

  // Access-offset decode used by both the write and read paths.
  function isAt;
    input [3:0] adr;
    input [3:0] ofs;
    begin
      isAt = (adr == ofs);
    end
  endfunction

  // Count enable from the selected source; external edges compare the live pin with a registered copy of it.
  reg tickSrc;
  always @* begin
    case (clockSelect)
      `PTM_CK_SYS4: tickSrc = (divSys_ff == `PTM_DIV_SYS4 - 8'd1);
      `PTM_CK_SYS:  tickSrc = 1'b1;
      `PTM_CK_H16:  tickSrc = highClkEn & (divHigh_ff[3:0] == 4'hf);
      `PTM_CK_H64:  tickSrc = highClkEn & (divHigh_ff[5:0] == 6'h3f);
      `PTM_CK_SUB0: tickSrc = subClkEn;
      `PTM_CK_SUB1: tickSrc = subClkEn;
      `PTM_CK_EXTR: tickSrc = externalClockPin & ~extPrev_ff;
      `PTM_CK_EXTF: tickSrc = ~externalClockPin & extPrev_ff;
      default:      tickSrc = 1'b0;
    endcase
  end
  wire tick = tickSrc & runEnable & ~countPause;

  // Comparators run every cycle against the live count.
  wire eqA      = (counter_ff == cmpA_ff);
  wire eqP      = (counter_ff == cmpP_ff);
  wire atMax    = (counter_ff == `PTM_CNT_MAX);
  wire isPwm    = (modeSelect == `PTM_MODE_PWM);
  wire isCap    = (modeSelect == `PTM_MODE_CAP);
  wire cmpLike  = (modeSelect == `PTM_MODE_CMP) | (modeSelect == `PTM_MODE_TMR);
  // A hit is taken when the counter is about to leave the matching value.
  wire hitA     = tick & eqA & (cmpA_ff != {CNT_W{1'b0}});
  wire hitP     = tick & eqP & (cmpP_ff != {CNT_W{1'b0}}) & ~(cmpLike & clearSel);
  wire overflow = tick & atMax;
  reg  clearNow;
  always @* begin
    if (cmpLike) begin
      clearNow = clearSel ? hitA : (hitP | (overflow & (cmpP_ff == {CNT_W{1'b0}})));
    end else begin
      clearNow = hitP | (overflow & (cmpP_ff == {CNT_W{1'b0}}));
    end
  end

  // Capture trigger edge selection.
  wire trig     = captureSrc ? externalClockPin : captureInputPin;
  reg  capEdge;
  always @* begin
    case (pinFunction)
      2'h0:    capEdge = trig & ~trigPrev_ff;
      2'h1:    capEdge = ~trig & trigPrev_ff;
      2'h2:    capEdge = trig ^ trigPrev_ff;
      default: capEdge = 1'b0;
    endcase
  end

  // Prescalers and edge history.
  always @(posedge clk) begin
    if (!rst_n) begin
      divSys_ff   <= 8'h00;
      divHigh_ff  <= 8'h00;
      extPrev_ff  <= 1'b0;
      trigPrev_ff <= 1'b0;
      runPrev_ff  <= 1'b0;
    end else begin
      divSys_ff   <= (divSys_ff == `PTM_DIV_SYS4 - 8'd1) ? 8'h00 : divSys_ff + 8'd1;
      if (highClkEn) begin
        divHigh_ff <= (divHigh_ff == `PTM_DIV_H64 - 8'd1) ? 8'h00 : divHigh_ff + 8'd1;
      end
      extPrev_ff  <= externalClockPin;
      trigPrev_ff <= trig;
      runPrev_ff  <= runEnable;
    end
  end

  // Counter: no software write path, cleared only by a run rise or by match and overflow.
  always @(posedge clk) begin
    if (!rst_n) begin
      counter_ff <= {CNT_W{1'b0}};
    end else if (runRise) begin
      counter_ff <= {CNT_W{1'b0}};
    end else if (clearNow | overflow) begin
      counter_ff <= {CNT_W{1'b0}};
    end else if (tick) begin
      counter_ff <= counter_ff + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Match request pulses and the counter capture register.
  always @(posedge clk) begin
    if (!rst_n) begin
      matchAPulse <= 1'b0;
      matchPPulse <= 1'b0;
      capture_ff  <= {CNT_W{1'b0}};
    end else begin
      matchAPulse <= hitA & ~runRise;
      matchPPulse <= (hitP | (overflow & ~clearSel & (cmpP_ff == {CNT_W{1'b0}}))) & ~runRise;
      if (isCap & runEnable & capEdge) begin
        capture_ff <= counter_ff;
      end
    end
  end

  // Output level before polarity: compare, PWM and single pulse behaviour.
  always @(posedge clk) begin
    if (!rst_n) begin
      outLevel_ff  <= 1'b0;
      pulseDone_ff <= 1'b0;
    end else if (runRise) begin
      outLevel_ff  <= isPwm ? ~outputCtl : outputCtl;
      pulseDone_ff <= 1'b0;
      if (isPwm & (pinFunction == 2'h3)) begin
        outLevel_ff <= outputCtl;
      end
    end else if (modeSelect == `PTM_MODE_CMP) begin
      if (hitA) begin
        case (pinFunction)
          2'h1:    outLevel_ff <= 1'b0;
          2'h2:    outLevel_ff <= 1'b1;
          2'h3:    outLevel_ff <= ~outLevel_ff;
          default: outLevel_ff <= outLevel_ff;
        endcase
      end
    end else if (isPwm) begin
      case (pinFunction)
        2'h0:    outLevel_ff <= ~outputCtl;
        2'h1:    outLevel_ff <= outputCtl;
        2'h2:    outLevel_ff <= (counter_ff < cmpA_ff) ? outputCtl : ~outputCtl;
        default: begin
          if ((hitA | clearNow) & ~pulseDone_ff) begin
            outLevel_ff  <= ~outputCtl;
            pulseDone_ff <= 1'b1;
          end
        end
      endcase
    end
  end

  // Pins; timer/counter mode ignores polarity but keeps the control level, the inverted pin is the complement of the primary.
  wire polApplied = (modeSelect == `PTM_MODE_TMR) ? 1'b0 : outputPol;
  wire pinNext    = outLevel_ff ^ polApplied;
  always @(posedge clk) begin
    if (!rst_n) begin
      timerOutputPin         <= 1'b0;
      timerOutputInvertedPin <= 1'b1;
    end else begin
      timerOutputPin         <= pinNext;
      timerOutputInvertedPin <= ~pinNext;
    end
  end

  // Register writes; the high-byte write commits the shared buffer to the low half.
  always @(posedge clk) begin
    if (!rst_n) begin
      ctrl0_ff    <= `PTM_CTRL0_RESET;
      ctrl1_ff    <= `PTM_CTRL1_RESET;
      cmpA_ff     <= {CNT_W{1'b0}};
      cmpP_ff     <= {CNT_W{1'b0}};
      stageBuf_ff <= 8'h00;
    end else begin
      if (busWr & isAt(wb_adr_i, `PTM_OFS_CTRL0)) begin
        ctrl0_ff <= wb_dat_i & `PTM_CTRL0_WMASK;
      end
      if (busWr & isAt(wb_adr_i, `PTM_OFS_CTRL1)) begin
        ctrl1_ff <= wb_dat_i;
      end
      if (busWr & (isAt(wb_adr_i, `PTM_OFS_CMPA_LO) | isAt(wb_adr_i, `PTM_OFS_CMPP_LO))) begin
        stageBuf_ff <= wb_dat_i;
      end
      if (busWr & isAt(wb_adr_i, `PTM_OFS_CMPA_HI)) begin
        cmpA_ff <= {wb_dat_i[CNT_W-9:0], stageBuf_ff};
      end
      if (busWr & isAt(wb_adr_i, `PTM_OFS_CMPP_HI)) begin
        cmpP_ff <= {wb_dat_i[CNT_W-9:0], stageBuf_ff};
      end
      if (busRd & isAt(wb_adr_i, `PTM_OFS_CNT_HI)) begin
        stageBuf_ff <= counter_ff[7:0];
      end
      if (busRd & isAt(wb_adr_i, `PTM_OFS_CMPA_HI)) begin
        stageBuf_ff <= cmpA_ff[7:0];
      end
      if (busRd & isAt(wb_adr_i, `PTM_OFS_CMPP_HI)) begin
        stageBuf_ff <= cmpP_ff[7:0];
      end
    end
  end

  // Read mux; low bytes return the staging buffer, unmapped offsets read zero.
  reg [7:0] nxt_rdData;
  always @* begin
    nxt_rdData = 8'h00;
    case (wb_adr_i)
      `PTM_OFS_CTRL0:   nxt_rdData = ctrl0_ff;
      `PTM_OFS_CTRL1:   nxt_rdData = ctrl1_ff;
      `PTM_OFS_CNT_LO:  nxt_rdData = stageBuf_ff;
      `PTM_OFS_CNT_HI:  nxt_rdData = {6'h00, counter_ff[CNT_W-1:8]};
      `PTM_OFS_CMPA_LO: nxt_rdData = stageBuf_ff;
      `PTM_OFS_CMPA_HI: nxt_rdData = {6'h00, cmpA_ff[CNT_W-1:8]};
      `PTM_OFS_CMPP_LO: nxt_rdData = stageBuf_ff;
      `PTM_OFS_CMPP_HI: nxt_rdData = {6'h00, cmpP_ff[CNT_W-1:8]};
      `PTM_OFS_STATUS:  nxt_rdData = {6'h00, capture_ff[CNT_W-1:8]};
      default:          nxt_rdData = 8'h00;
    endcase
  end

  // Single-wait-state ack; it drops the cycle after it is given.
  always @(posedge clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 8'h00;
      status_ff <= 2'h0;
    end else begin
      wb_ack_o <= busReq;
      wb_dat_o <= busRd ? nxt_rdData : 8'h00;
      status_ff <= 2'h0;
    end
  end
endmodule

/* src/ptm_timer_map.vh */
// Register offsets, field positions, reset values and timing counts for the periodic timer.
// Assumes inclusion by the periodic timer design and by the verification side; definitions only.
`ifndef PTM_TIMER_MAP_VH
`define PTM_TIMER_MAP_VH
`define PTM_OFS_CTRL0     4'h0
`define PTM_OFS_CTRL1     4'h1
`define PTM_OFS_CNT_LO    4'h2
`define PTM_OFS_CNT_HI    4'h3
`define PTM_OFS_CMPA_LO   4'h4
`define PTM_OFS_CMPA_HI   4'h5
`define PTM_OFS_CMPP_LO   4'h6
`define PTM_OFS_CMPP_HI   4'h7
`define PTM_OFS_STATUS    4'h8
`define PTM_CTRL0_RESET   8'h00
`define PTM_CTRL1_RESET   8'h00
`define PTM_CTRL0_WMASK   8'hf8
`define PTM_C0_PAUSE      7
`define PTM_C0_CKSEL_HI   6
`define PTM_C0_CKSEL_LO   4
`define PTM_C0_RUN        3
`define PTM_C1_MODE_HI    7
`define PTM_C1_MODE_LO    6
`define PTM_C1_PIN_HI     5
`define PTM_C1_PIN_LO     4
`define PTM_C1_OCTL       3
`define PTM_C1_POL        2
`define PTM_C1_CAPSRC     1
`define PTM_C1_CLRSEL     0
`define PTM_MODE_CMP      2'h0
`define PTM_MODE_CAP      2'h1
`define PTM_MODE_PWM      2'h2
`define PTM_MODE_TMR      2'h3
`define PTM_CK_SYS4       3'h0
`define PTM_CK_SYS        3'h1
`define PTM_CK_H16        3'h2
`define PTM_CK_H64        3'h3
`define PTM_CK_SUB0       3'h4
`define PTM_CK_SUB1       3'h5
`define PTM_CK_EXTR       3'h6
`define PTM_CK_EXTF       3'h7
`define PTM_DIV_SYS4      8'd4
`define PTM_DIV_H16       8'd16
`define PTM_DIV_H64       8'd64
`define PTM_CNT_MAX       10'h3ff
`endif

/* verif/ptm_periodic_timer_sva.sv */
// Concurrent checks on the periodic timer's bus answers, pins and event pulses.
// Assumes it is bound to ptm_periodic_timer and sees only that module's ports.
`timescale 1ns/1ps
`include "ptm_timer_map.vh"
module ptm_periodic_timer_sva #(
  parameter CNT_W = 10
) (
  // Clock, reset and bus.
  input wire       clk,
  input wire       rst_n,
  input wire       wb_cyc_i,
  input wire       wb_stb_i,
  input wire       wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [7:0] wb_dat_i,
  input wire       wb_sel_i,
  input wire [7:0] wb_dat_o,
  input wire       wb_ack_o,
  // Pins and events.
  input wire       timerOutputPin,
  input wire       timerOutputInvertedPin,
  input wire       matchAPulse,
  input wire       matchPPulse
);
  logic       ctrlRun_ff;
  logic       ctrlPause_ff;
  logic [3:0] frozen_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Shadow run and pause; a tick already in flight may still land, so events are judged after a few cycles.
  always @(posedge clk) begin
    if (!rst_n) begin
      ctrlRun_ff <= 1'b0;
      ctrlPause_ff <= 1'b0;
      frozen_ff <= 4'h0;
    end else begin
      if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i && wb_adr_i == `PTM_OFS_CTRL0) begin
        ctrlRun_ff <= wb_dat_i[`PTM_C0_RUN];
        ctrlPause_ff <= wb_dat_i[`PTM_C0_PAUSE];
      end
      if (ctrlRun_ff && !ctrlPause_ff)
        frozen_ff <= 4'h0;
      else if (frozen_ff != 4'hf)
        frozen_ff <= frozen_ff + 4'h1;
    end
  end
  // A request is taken when no answer is pending; reads are split out by index.
  sequence sTaken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence sRead(a);
    sTaken ##0 !wb_we_i && a;
  endsequence
  a_ack_follows: assert property (sTaken |=> wb_ack_o)
    else $error("ack missing after a taken request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_data_quiet: assert property (!wb_ack_o |-> wb_dat_o == 8'h00)
    else $error("read data driven outside ack");
  a_ctrl0_unused: assert property (sRead(wb_adr_i == `PTM_OFS_CTRL0) |=> wb_dat_o[2:0] == 3'h0)
    else $error("unused control bits read nonzero");
  a_high_upper: assert property (sRead(wb_adr_i == 4'h3 || wb_adr_i == 4'h5 || wb_adr_i == 4'h7)
    |=> wb_dat_o[7:2] == 6'h00) else $error("high byte upper bits nonzero");
  a_unmapped_zero: assert property (sRead(wb_adr_i > `PTM_OFS_STATUS) |=> wb_dat_o == 8'h00)
    else $error("unmapped read nonzero");
  a_inverse_pin: assert property (timerOutputInvertedPin == !timerOutputPin)
    else $error("complementary pin not inverse");
  a_pulse_single: assert property (matchAPulse |=> !matchAPulse)
    else $error("match pulse longer than one cycle");
  a_frozen_quiet: assert property (frozen_ff > 4'h3 |-> !matchAPulse && !matchPPulse)
    else $error("event while counter frozen");
endmodule
bind ptm_periodic_timer ptm_periodic_timer_sva #(.CNT_W(CNT_W)) i_ptm_periodic_timer_sva (
  .clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o,
  .timerOutputPin, .timerOutputInvertedPin, .matchAPulse, .matchPPulse
);

/* verif/ptm_periodic_timer_tb_top.sv */
// Self-checking bench for the periodic timer: registers, clock sources, clears, hold and pins.
// Assumes the timer design and its map header; the bench is the only bus master.
`timescale 1ns/1ps
`include "ptm_timer_map.vh"
module ptm_periodic_timer_tb_top;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       cyc = 1'b0;
  logic       we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [7:0] wdat = 8'h00;
  logic [7:0] rdat;
  logic       ack;
  logic       hiEn = 1'b0;
  logic       subEn = 1'b0;
  logic       extPin = 1'b0;
  logic       pin;
  logic       pulseA;
  logic       pulseP;
  logic [7:0] q, h1, l1, h2, l2;
  logic [9:0] v;
  logic [1:0] m, pf;
  logic       oc, pol;
  int         tick = 0;
  int         len;
  int         miscompares = 0;
  int         num_checks = 0;
  // Clock of 8 ns.
  always #4 clk = ~clk;
  // Sources: high clock every 2nd cycle, sub clock every 3rd, external pin period 4.
  always @(posedge clk) begin
    tick <= tick + 1;
    hiEn <= (tick % 2 == 0);
    subEn <= (tick % 3 == 0);
    extPin <= tick[1];
  end
  ptm_periodic_timer i_ptm_periodic_timer (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(1'b1), .wb_dat_o(rdat), .wb_ack_o(ack), .highClkEn(hiEn),
    .subClkEn(subEn), .externalClockPin(extPin), .captureInputPin(1'b0), .timerOutputPin(pin),
    .timerOutputInvertedPin(), .matchAPulse(pulseA), .matchPPulse(pulseP)
  );
  // One classic cycle launched just after a rising edge; ack and read data are taken at a rising edge.
  // Callers may arrive on either edge, so the request always waits for a rising edge first.
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    r = rdat;
    if (n >= 40)
      miscompares++;
    cyc <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic setCmp(input logic [3:0] a, input logic [9:0] d);
    wr(a, d[7:0]);
    wr(a + 4'h1, {6'h00, d[9:8]});
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Counts cycles up to the next event pulse, capped at 3000 so a stuck counter ends the wait.
  task automatic waitPulse(input logic p, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((p ? pulseP : pulseA) !== 1'b1 && n < 3000);
  endtask
  function automatic int factor(input logic [2:0] s);
    case (s)
      3'h0: return 4;
      3'h1: return 1;
      3'h2: return 32;
      3'h3: return 128;
      3'h4, 3'h5: return 3;
      default: return 4;
    endcase
  endfunction
  // Pin level from mode, pin function, output control and polarity, before or after an A match.
  function automatic logic expPin(input logic [1:0] md, input logic [1:0] f, input logic c, input logic p,
                                  input logic hit);
    logic l;
    l = c;
    if (md == `PTM_MODE_PWM)
      l = (f == 2'h1) ? c : ~c;
    else if (hit && f != 2'h0)
      l = (f == 2'h3) ? ~c : f[1];
    return l ^ p;
  endfunction
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog well beyond the expected run of under seven thousand cycles.
  initial begin
    #400000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    void'($urandom(1));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, `PTM_OFS_CTRL1, 8'h00, q);
    chk(q, `PTM_CTRL1_RESET);
    bus(1'b0, 4'hf, 8'h00, q);
    chk(q, 8'h00);
    wr(`PTM_OFS_CTRL0, 8'hff);
    bus(1'b0, `PTM_OFS_CTRL0, 8'h00, q);
    chk(q, 8'hf8);
    wr(`PTM_OFS_CTRL0, 8'h00);
    $display("test registers done");
    for (int b = 4; b < 8; b += 2) begin
      v = 10'($urandom);
      setCmp(b[3:0], v);
      bus(1'b0, b[3:0] + 4'h1, 8'h00, q);
      chk(q, {6'h00, v[9:8]});
      bus(1'b0, b[3:0], 8'h00, q);
      chk(q, v[7:0]);
      wr(b[3:0], ~v[7:0]);
      bus(1'b0, b[3:0] + 4'h1, 8'h00, q);
      bus(1'b0, b[3:0], 8'h00, q);
      chk(q, v[7:0]);
    end
    $display("test buffered pairs done");
    for (int s = 0; s < 8; s++) begin
      v = 10'd3 + 10'($urandom % 8);
      wr(`PTM_OFS_CTRL0, 8'h00);
      wr(`PTM_OFS_CTRL1, 8'hc1);
      setCmp(`PTM_OFS_CMPA_LO, v);
      wr(`PTM_OFS_CTRL0, {1'b0, s[2:0], 4'h8});
      repeat (3) waitPulse(1'b0, len);
      chk(16'(len), 16'(factor(s[2:0]) * (v + 1)));
    end
    v = 10'd3 + 10'($urandom % 8);
    wr(`PTM_OFS_CTRL0, 8'h00);
    wr(`PTM_OFS_CTRL1, 8'hc0);
    setCmp(`PTM_OFS_CMPA_LO, 10'h3ff);
    setCmp(`PTM_OFS_CMPP_LO, v);
    wr(`PTM_OFS_CTRL0, 8'h18);
    repeat (3) waitPulse(1'b1, len);
    chk(16'(len), 16'(v + 10'h1));
    $display("test clock and clear done");
    setCmp(`PTM_OFS_CMPP_LO, 10'h000);
    repeat (300) @(posedge clk);
    wr(`PTM_OFS_CTRL0, 8'h98);
    bus(1'b0, `PTM_OFS_CNT_HI, 8'h00, h1);
    bus(1'b0, `PTM_OFS_CNT_LO, 8'h00, l1);
    wr(`PTM_OFS_CNT_HI, 8'h03);
    wr(`PTM_OFS_CNT_LO, 8'hff);
    bus(1'b0, `PTM_OFS_CNT_HI, 8'h00, h2);
    bus(1'b0, `PTM_OFS_CNT_LO, 8'h00, l2);
    chk({h2, l2}, {h1, l1});
    wr(`PTM_OFS_CTRL0, 8'h18);
    wr(`PTM_OFS_CTRL0, 8'h10);
    bus(1'b0, `PTM_OFS_CNT_HI, 8'h00, h1);
    bus(1'b0, `PTM_OFS_CNT_LO, 8'h00, l1);
    repeat (50) @(posedge clk);
    bus(1'b0, `PTM_OFS_CNT_HI, 8'h00, h2);
    bus(1'b0, `PTM_OFS_CNT_LO, 8'h00, l2);
    chk({h2, l2}, {h1, l1});
    wr(`PTM_OFS_CTRL0, 8'h08);
    bus(1'b0, `PTM_OFS_CNT_HI, 8'h00, h1);
    bus(1'b0, `PTM_OFS_CNT_LO, 8'h00, l1);
    chk({h1, 7'h00, l1 < 8'h04}, 16'h0001);
    $display("test hold and restart done");
    for (int i = 0; i < 6; i++) begin
      m = (i < 4) ? `PTM_MODE_CMP : `PTM_MODE_PWM;
      pf = 2'(i % 4);
      {oc, pol} = 2'($urandom);
      v = 10'd3 + 10'($urandom % 8);
      wr(`PTM_OFS_CTRL0, 8'h00);
      setCmp(`PTM_OFS_CMPA_LO, v);
      wr(`PTM_OFS_CTRL1, {m, pf, oc, pol, 2'b01});
      wr(`PTM_OFS_CTRL0, 8'h18);
      // The forced PWM levels settle one cycle after the start level, so look once both have passed.
      repeat (2) @(negedge clk);
      chk(pin, expPin(m, pf, oc, pol, 1'b0));
      if (m == `PTM_MODE_CMP) begin
        waitPulse(1'b0, len);
        repeat (2) @(negedge clk);
        chk(pin, expPin(m, pf, oc, pol, 1'b1));
      end
    end
    $display("test output pin done");
    report_and_stop();
  end
endmodule
